// *** arinc_pkg.sv ***
/*
 Shared constants, register map, control word layout and types for the
 serial bus receiver/transmitter core.
 Assumes a 25 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
package arinc_pkg;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_HZ = 1_000_000;
  localparam int BIT_HZ = 100_000;
  localparam int SLOW_FACTOR = 8;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int HALF_DIV = CLK_HZ / (2 * BIT_HZ);
  localparam logic [7:0] SAMPLE_LIM_FAST = 8'(SAMPLE_DIV - 1);
  localparam logic [7:0] SAMPLE_LIM_SLOW = 8'(SAMPLE_DIV * SLOW_FACTOR - 1);
  localparam logic [9:0] HALF_LIM_FAST = 10'(HALF_DIV - 1);
  localparam logic [9:0] HALF_LIM_SLOW = 10'(HALF_DIV * SLOW_FACTOR - 1);
  localparam logic [4:0] BREAK_SAMPLES = 5'h0f;
  localparam logic [3:0] GAP_HALVES = 4'h8;
  // Word lengths
  localparam logic [5:0] LEN_LONG = 6'h20;
  localparam logic [5:0] LEN_SHORT = 6'h19;
  localparam logic [5:0] TX_DATA_LONG = 6'h1f;
  localparam logic [5:0] TX_DATA_SHORT = 6'h18;
  // Register byte addresses
  localparam logic [5:0] ADDR_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_TX_CTRL = 6'h04;
  localparam logic [5:0] ADDR_TX_FIRST = 6'h08;
  localparam logic [5:0] ADDR_TX_SECOND = 6'h0c;
  localparam logic [5:0] ADDR_RX1_FIRST = 6'h10;
  localparam logic [5:0] ADDR_RX1_SECOND = 6'h14;
  localparam logic [5:0] ADDR_RX2_FIRST = 6'h18;
  localparam logic [5:0] ADDR_RX2_SECOND = 6'h1c;
  localparam logic [5:0] ADDR_STATUS = 6'h20;
  // Field positions
  localparam int TX_GO_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0020;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic word_length_choice;
    logic rx_rate_choice;
    logic tx_rate_choice;
    logic parity_polarity;
    logic rx2_match_bit10;
    logic rx2_match_bit9;
    logic rx2_filter_enable;
    logic rx1_match_bit10;
    logic rx1_match_bit9;
    logic rx1_filter_enable;
    logic loopback_test_n;
    logic [4:0] spare;
  } ctrl_type;

  typedef struct packed {
    logic hi;
    logic lo;
  } line_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_GAP = 2'b10
  } tx_state_type;
endpackage

// *** arinc_serial_rx_tx_core.sv ***
/*
 Dual receiver and FIFO transmitter for a return-to-zero avionics serial bus,
 with an AXI4-Lite register slave.
 Assumes line inputs are logic-level copies of the differential receivers,
 asynchronous to aclk, and a single 25 MHz clock for all sections.
*/
// Notes on behaviour
// R1 - 32-bit first half bit shuffle
// R2 - 32-bit second half sign, MSB, data
// R3 - 25-bit halves layout
// R4 - no address match in 25-bit mode
// R5 - parity status: 0 odd, 1 even
// R6 - broken word discarded silently
// R7 - sample at ten times bit rate
// R8 - 25/32 bit word, completion pulse
// R9 - filter on bits 9 and 10
// R10 - latching sets word ready flag
// R11 - overwrite unread; halves readable repeatedly
// R12 - half select then read strobe
// R13 - second half read clears ready
// R14 - eight word 31-bit fall-through FIFO
// R15 - first then second half, second pushes
// R16 - full FIFO: input register overwritten
// R17 - hold until go; load only idle
// R18 - send 24 or 31 data bits
// R19 - four bit null gap between words
// R20 - advance per word, ready when empty
// R21 - go toggle mid-word stops transmission
// R22 - append parity, polarity selectable
// R23 - control word latched by strobe
// R24 - master clear spares control word
// R25 - rate divide by ten or eighty
// R26 - loopback: rx1 true, rx2 inverted
// R27 - transmitter ready after clear
`timescale 1ns/1ps
module arinc_serial_rx_tx_core import arinc_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [5:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [5:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial line
  input wire line_type rx1_line,
  input wire line_type rx2_line,
  output line_type tx_line
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : depth_check
    $error("FIFO_DEPTH must be a power of two from 2 to 64");
  end

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      rev8[k] = v[7 - k];
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // R1 first half shuffle
  // R2 second half layout
  // R3 short word halves
  function automatic logic [15:0] rx_half(input logic [31:0] w, input logic par, input logic second,
                                          input logic short);
    if (short) begin
      rx_half = second ? {w[23], w[22:9], w[8]} : {7'h00, par, rev8(w[7:0])};
    end else begin
      rx_half = second ? {w[28:27], w[26:13]} : {w[12:8], w[30:29], par, rev8(w[7:0])};
    end
  endfunction

  // R15 assemble loaded halves
  function automatic logic [30:0] tx_word(input logic [15:0] a, input logic [15:0] b, input logic short);
    tx_word = '0;
    tx_word[7:0] = rev8(a[7:0]);
    if (short) begin
      tx_word[23:8] = {b[15], b[14:1], b[0]};
    end else begin
      tx_word[12:8] = a[15:11];
      tx_word[30:29] = a[10:9];
      tx_word[28:13] = b;
    end
  endfunction

  ctrl_type ctrl;
  logic short;
  logic tx_go;
  logic clear;
  logic rst_all;
  logic [15:0] first_half;
  logic [15:0] second_half;
  // AXI state
  logic aw_held;
  logic w_held;
  logic [5:0] waddr;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic rd_take;
  logic rd_ok;
  logic [15:0] rd_val;
  // Receivers
  line_type sync1 [2];
  line_type sync2 [2];
  line_type src [2];
  logic [1:0] active;
  logic [1:0] was_null;
  logic [1:0] bit_edge;
  logic [1:0] complete;
  logic [1:0] accept;
  logic [1:0] read_second;
  logic [1:0] rx_ready;
  logic [1:0] par_st;
  logic [1:0] flt_en;
  logic [1:0] flt_x;
  logic [1:0] flt_y;
  logic [31:0] sr [2];
  logic [31:0] next_sr [2];
  logic [31:0] word [2];
  logic [31:0] hold [2];
  logic [5:0] bit_cnt [2];
  logic [4:0] quiet [2];
  logic [7:0] sample_cnt;
  logic sample_tick;
  logic [5:0] rx_len;
  // Transmitter
  logic [30:0] mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;
  logic full;
  tx_state_type state;
  logic [9:0] half_cnt;
  logic half_tick;
  logic phase;
  logic [5:0] bit_idx;
  logic [5:0] tx_bits;
  logic [30:0] out_word;
  logic par_bit;
  logic [3:0] gap_cnt;
  line_type next_line;

  assign short = ctrl.word_length_choice;
  assign rst_all = !aresetn || clear;
  assign flt_en = {ctrl.rx2_filter_enable, ctrl.rx1_filter_enable};
  assign flt_x = {ctrl.rx2_match_bit9, ctrl.rx1_match_bit9};
  assign flt_y = {ctrl.rx2_match_bit10, ctrl.rx1_match_bit10};

  // Write channel: address and data taken in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_go = aw_held && w_held && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        waddr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (waddr == ADDR_CONTROL || waddr == ADDR_TX_CTRL || waddr == ADDR_TX_FIRST ||
                  waddr == ADDR_TX_SECOND) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // R24 master clear pulse
  assign clear = wr_go && waddr == ADDR_TX_CTRL && wstrb_r[0] && wdata_r[CLEAR_BIT];

  // R23 control word latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ctrl_type'(CTRL_RESET);
    end else if (wr_go && waddr == ADDR_CONTROL) begin
      ctrl <= ctrl_type'(merge16(ctrl, wdata_r, wstrb_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_go <= 1'b0;
      first_half <= '0;
      second_half <= '0;
    end else if (wr_go) begin
      if (waddr == ADDR_TX_CTRL && wstrb_r[0]) begin
        tx_go <= wdata_r[TX_GO_BIT];
      end
      // R15 repeated first loads overwrite
      if (waddr == ADDR_TX_FIRST) begin
        first_half <= merge16(first_half, wdata_r, wstrb_r);
      end
      // R16 input register overwritten when full
      if (waddr == ADDR_TX_SECOND) begin
        second_half <= merge16(second_half, wdata_r, wstrb_r);
      end
    end
  end

  // Read channel
  assign arready = !rvalid;
  assign rd_take = arvalid && arready;
  // R12 half chosen by address
  assign read_second[0] = rd_take && araddr == ADDR_RX1_SECOND;
  assign read_second[1] = rd_take && araddr == ADDR_RX2_SECOND;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = '0;
    case (araddr)
      ADDR_CONTROL: rd_val = ctrl;
      ADDR_TX_CTRL: rd_val = {15'h0000, tx_go};
      ADDR_RX1_FIRST: rd_val = rx_half(hold[0], par_st[0], 1'b0, short);
      ADDR_RX1_SECOND: rd_val = rx_half(hold[0], par_st[0], 1'b1, short);
      ADDR_RX2_FIRST: rd_val = rx_half(hold[1], par_st[1], 1'b0, short);
      ADDR_RX2_SECOND: rd_val = rx_half(hold[1], par_st[1], 1'b1, short);
      // R27 transmitter ready when empty
      ADDR_STATUS: rd_val = {8'(count), 4'h0, full, count == '0, rx_ready};
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_val};
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Line input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1[0] <= '0;
      sync1[1] <= '0;
      sync2[0] <= '0;
      sync2[1] <= '0;
    end else begin
      sync1[0] <= rx1_line;
      sync1[1] <= rx2_line;
      sync2[0] <= sync1[0];
      sync2[1] <= sync1[1];
    end
  end

  // R7 sample tick at ten per bit
  // R25 receive rate choice
  assign sample_tick = sample_cnt == (ctrl.rx_rate_choice ? SAMPLE_LIM_SLOW : SAMPLE_LIM_FAST);
  always_ff @(posedge aclk) begin
    if (rst_all || sample_tick) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + 8'h01;
    end
  end

  assign rx_len = short ? LEN_SHORT : LEN_LONG;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src[i] = sync2[i];
      // R26 loopback from transmitter
      if (!ctrl.loopback_test_n) begin
        src[i] = (i == 0) ? tx_line : line_type'({tx_line.lo, tx_line.hi});
      end
      active[i] = src[i].hi ^ src[i].lo;
      bit_edge[i] = sample_tick && active[i] && was_null[i];
      next_sr[i] = {src[i].hi, sr[i][31:1]};
      // R8 word complete pulse
      complete[i] = bit_edge[i] && bit_cnt[i] == rx_len - 6'h01;
      word[i] = short ? {7'h00, next_sr[i][31:7]} : next_sr[i];
      // R9 address match filter
      // R4 no match in short mode
      accept[i] = complete[i] && (short || !flt_en[i] || word[i][9:8] == {flt_y[i], flt_x[i]});
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_all) begin
        sr[i] <= '0;
        bit_cnt[i] <= '0;
        quiet[i] <= '0;
        was_null[i] <= 1'b1;
      end else if (sample_tick) begin
        was_null[i] <= !active[i];
        if (bit_edge[i]) begin
          sr[i] <= next_sr[i];
          bit_cnt[i] <= complete[i] ? 6'h00 : bit_cnt[i] + 6'h01;
          quiet[i] <= '0;
        end else if (quiet[i] == BREAK_SAMPLES) begin
          // R6 broken word dropped
          bit_cnt[i] <= '0;
        end else begin
          quiet[i] <= quiet[i] + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_all) begin
        hold[i] <= '0;
        par_st[i] <= 1'b0;
        rx_ready[i] <= 1'b0;
      end else if (accept[i]) begin
        // R11 unread word overwritten
        // R10 latch sets ready
        // R5 parity status stored
        hold[i] <= word[i];
        par_st[i] <= ~^word[i];
        rx_ready[i] <= 1'b1;
      end else if (read_second[i]) begin
        // R13 second read clears ready
        rx_ready[i] <= 1'b0;
      end
    end
  end

  // R17 loads refused while go is set
  assign full = count == CW'(FIFO_DEPTH);
  assign push = wr_go && waddr == ADDR_TX_SECOND && !tx_go && !full;
  assign pop = state == TX_IDLE && tx_go && count != '0;

  // R14 fall-through word store
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= tx_word(first_half, merge16(second_half, wdata_r, wstrb_r), short);
    end
  end
  // R20 advance one word per send
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // R18 data bit count
  // R25 transmit rate choice
  assign tx_bits = short ? TX_DATA_SHORT : TX_DATA_LONG;
  assign half_tick = state != TX_IDLE && half_cnt == (ctrl.tx_rate_choice ? HALF_LIM_SLOW : HALF_LIM_FAST);
  always_ff @(posedge aclk) begin
    if (rst_all || state == TX_IDLE || half_tick) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      state <= TX_IDLE;
      out_word <= '0;
      par_bit <= 1'b0;
      phase <= 1'b0;
      bit_idx <= '0;
      gap_cnt <= '0;
    end else begin
      case (state)
        TX_IDLE: begin
          if (pop) begin
            out_word <= mem[rd_ptr];
            // R22 odd or even parity
            par_bit <= ~^(short ? {7'h00, mem[rd_ptr][23:0]} : mem[rd_ptr]) ^ ctrl.parity_polarity;
            phase <= 1'b0;
            bit_idx <= '0;
            state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (!tx_go) begin
            // R21 stop mid-word
            state <= TX_IDLE;
          end else if (half_tick) begin
            phase <= !phase;
            if (phase) begin
              if (bit_idx == tx_bits) begin
                gap_cnt <= '0;
                state <= TX_GAP;
              end else begin
                bit_idx <= bit_idx + 6'h01;
                out_word <= {1'b0, out_word[30:1]};
              end
            end
          end
        end
        TX_GAP: begin
          // R19 four bit null gap
          if (half_tick) begin
            gap_cnt <= gap_cnt + 4'h1;
            if (gap_cnt == GAP_HALVES - 4'h1) begin
              state <= TX_IDLE;
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    next_line = '0;
    if (state == TX_DATA && tx_go && !phase) begin
      next_line.hi = (bit_idx == tx_bits) ? par_bit : out_word[0];
      next_line.lo = !next_line.hi;
    end
  end
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      tx_line <= '0;
    end else begin
      tx_line <= next_line;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ready_set_a: assert property (accept[0] && !clear |=> rx_ready[0] && hold[0] == $past(word[0])) // R10
    else $error("rx1 ready not set on latch");
  ready_clear_a: assert property (read_second[1] && !accept[1] && !clear |=> !rx_ready[1]) // R13
    else $error("rx2 ready not cleared");
  filter_block_a: assert property (complete[0] && !short && flt_en[0] && word[0][8] != flt_x[0]
    |=> $stable(hold[0])) // R9
    else $error("mismatched word latched");
  short_nofilter_a: assert property (complete[0] && short |-> accept[0]) // R4
    else $error("filter active in short mode");
  break_drop_a: assert property (sample_tick && quiet[0] == BREAK_SAMPLES && !bit_edge[0] && !clear
    |=> bit_cnt[0] == 6'h00 && !accept[0]) // R6
    else $error("partial word kept");
  full_keep_a: assert property (full && wr_go && waddr == ADDR_TX_SECOND && !clear |=> full) // R16
    else $error("full store disturbed");
  gap_null_a: assert property (state == TX_GAP ##1 state == TX_GAP |-> tx_line == '0) // R19
    else $error("line not null in gap");
  stop_idle_a: assert property (state == TX_DATA && !tx_go && !clear |=> state == TX_IDLE ##1 tx_line == '0) // R21
    else $error("transmit did not stop");
  clear_empty_a: assert property (clear |=> count == '0 && rx_ready == 2'b00) // R24
    else $error("master clear incomplete");
  clear_keep_a: assert property (clear |=> $stable(ctrl)) // R24
    else $error("control word lost on clear");

  rx_word_c: cover property (accept[0] ##[1:1000] read_second[0]);
  tx_gap_c: cover property (state == TX_GAP ##1 state == TX_IDLE ##1 state == TX_DATA);
  fifo_full_c: cover property (full);
endmodule

// *** line_partner.sv ***
/*
 Far-side model of the serial bus: sends words on the receive line pairs
 and records bits and null gaps seen on the transmit pair.
 Assumes a 25 MHz aclk and the fast bit rate (half bit of 125 cycles).
*/
`timescale 1ns/1ps
module line_partner import arinc_pkg::*; (
  // Clock
  input wire logic aclk,
  // Line pairs
  output line_type rx1_line,
  output line_type rx2_line,
  input wire line_type tx_line
);
  localparam int HALF = 125;
  logic q[$];
  int gaps[$];
  int run = 0;
  logic act;

  initial begin
    rx1_line = '0;
    rx2_line = '0;
  end

  task automatic send(input logic [31:0] w, input int n, input int ch);
    line_type v;
    for (int i = 0; i < n; i++) begin
      v = w[i] ? 2'b10 : 2'b01;
      repeat (2) begin
        @(posedge aclk);
        if (ch == 1) rx1_line <= v;
        else rx2_line <= v;
        repeat (HALF - 1) @(posedge aclk);
        v = '0;
      end
    end
  endtask

  always @(posedge aclk) begin
    act = tx_line.hi | tx_line.lo;
    if (act && run > 0) begin
      q.push_back(tx_line.hi);
      gaps.push_back(run);
    end
    run = act ? 0 : run + 1;
  end
endmodule

// *** testbench.sv ***
/*
 Self-checking bench for the serial bus core: register access over
 AXI4-Lite, receive through the line model, transmit through loopback.
 Assumes line_partner and arinc_pkg are compiled first.
*/
`timescale 1ns/1ps
module testbench import arinc_pkg::*;;
  localparam logic [31:0] W1 = 32'h9a5c_3e71;
  localparam logic [31:0] W2 = 32'h1234_5e77;
  localparam logic [31:0] W3 = 32'h6b0f_c1a3;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdat;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, rrsp, brsp;
  line_type rx1_line, rx2_line, tx_line;
  int num_errors = 0, total_checks = 0, cycles = 0;

  arinc_serial_rx_tx_core #(.FIFO_DEPTH(8)) uut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .rx1_line(rx1_line), .rx2_line(rx2_line), .tx_line(tx_line));
  line_partner line_far (.aclk(aclk), .rx1_line(rx1_line), .rx2_line(rx2_line), .tx_line(tx_line));

  always #20 aclk = ~aclk;

  task test_done;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready sampled at negedge equals its value at the next rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      brsp = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [5:0] a);
    logic ar_go, r_go;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    check(rdat, e);
  endtask

  task automatic wait_bit(input int b);
    int n = 0;
    rd(ADDR_STATUS);
    while (rdat[b] !== 1'b1 && n < 4000) begin
      rd(ADDR_STATUS);
      n++;
    end
    if (n == 4000) num_errors++;
  endtask

  // Expected bus half of a received word
  function automatic logic [31:0] half(input logic [31:0] w, input logic sec, input logic s25);
    logic [7:0] lab;
    for (int i = 0; i < 8; i++) lab[7 - i] = w[i];
    if (s25) return sec ? {16'h0, w[23:8]} : {23'h0, ~^w[24:0], lab};
    return sec ? {16'h0, w[28:13]} : {16'h0, w[12:8], w[30:29], ~^w, lab};
  endfunction

  task automatic t_reset;
    rdc(ADDR_STATUS, 32'h4);
    rdc(ADDR_CONTROL, {16'h0, CTRL_RESET});
    rdc(6'h24, 32'h0);
    check({30'h0, rrsp}, {30'h0, RESP_SLVERR});
    wr(ADDR_STATUS, 32'h0);
    check({30'h0, brsp}, {30'h0, RESP_SLVERR});
    rdc(ADDR_STATUS, 32'h4);
  endtask

  task automatic t_fifo;
    wr(ADDR_TX_CTRL, 32'h0);
    check({30'h0, brsp}, {30'h0, RESP_OKAY});
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_TX_FIRST, 32'(i));
      wr(ADDR_TX_SECOND, 32'(i));
      if (i == 0) rdc(ADDR_STATUS, 32'h100);
    end
    rdc(ADDR_STATUS, 32'h808);
    wr(ADDR_CONTROL, 32'h7c3f);
    wr(ADDR_TX_CTRL, 32'h2);
    rdc(ADDR_STATUS, 32'h4);
    rdc(ADDR_CONTROL, 32'h7c3f);
    wr(ADDR_CONTROL, 32'h20);
  endtask

  task automatic t_rx;
    line_far.send(W2, 10, 1);
    repeat (600) @(posedge aclk);
    rdc(ADDR_STATUS, 32'h4);
    line_far.send(W1, 32, 1);
    rdc(ADDR_STATUS, 32'h5);
    rdc(ADDR_RX1_FIRST, half(W1, 1'b0, 1'b0));
    rdc(ADDR_RX1_FIRST, half(W1, 1'b0, 1'b0));
    rdc(ADDR_STATUS, 32'h5);
    rdc(ADDR_RX1_SECOND, half(W1, 1'b1, 1'b0));
    rdc(ADDR_STATUS, 32'h4);
  endtask

  task automatic t_filter;
    wr(ADDR_CONTROL, 32'he0);
    line_far.send(W2, 32, 1);
    rdc(ADDR_STATUS, 32'h4);
    line_far.send(W3, 32, 1);
    rdc(ADDR_STATUS, 32'h5);
    rdc(ADDR_RX1_FIRST, half(W3, 1'b0, 1'b0));
    rdc(ADDR_RX1_SECOND, half(W3, 1'b1, 1'b0));
    wr(ADDR_CONTROL, 32'h80e0);
    line_far.send(W2, 25, 1);
    rdc(ADDR_STATUS, 32'h5);
    rdc(ADDR_RX1_FIRST, half(W2, 1'b0, 1'b1));
    rdc(ADDR_RX1_SECOND, half(W2, 1'b1, 1'b1));
  endtask

  task automatic t_loop;
    logic [31:0] w[2];
    logic [31:0] f[2];
    logic [63:0] g;
    w[0] = W1;
    w[1] = W3;
    wr(ADDR_CONTROL, 32'h1000);
    for (int k = 0; k < 2; k++) begin
      f[k] = {^w[k][30:0], w[k][30:0]};
      wr(ADDR_TX_FIRST, half(w[k], 1'b0, 1'b0));
      wr(ADDR_TX_SECOND, half(w[k], 1'b1, 1'b0));
    end
    rdc(ADDR_STATUS, 32'h200);
    wr(ADDR_TX_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wait_bit(0);
      rdc(ADDR_RX1_FIRST, half(f[k], 1'b0, 1'b0));
      rdc(ADDR_RX1_SECOND, half(f[k], 1'b1, 1'b0));
      rdc(ADDR_RX2_FIRST, half(~f[k], 1'b0, 1'b0));
      rdc(ADDR_RX2_SECOND, half(~f[k], 1'b1, 1'b0));
    end
    wait_bit(2);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_TX_CTRL, 32'h0);
    check(32'(line_far.q.size()), 32'd64);
    for (int i = 0; i < 64; i++) g[i] = line_far.q[i];
    check(g[31:0], f[0]);
    check(g[63:32], f[1]);
    check({31'h0, line_far.gaps[32] inside {[1000:1126]}}, 32'h1);
    check({31'h0, line_far.gaps[1] < 1000}, 32'h1);
  endtask

  // Go dropped mid-word: sending stops, word lost
  task automatic t_stop;
    int n;
    wr(ADDR_TX_FIRST, 32'h1);
    wr(ADDR_TX_SECOND, 32'h2);
    wr(ADDR_TX_CTRL, 32'h1);
    repeat (2000) @(posedge aclk);
    wr(ADDR_TX_CTRL, 32'h0);
    n = line_far.q.size();
    repeat (1000) @(posedge aclk);
    check(32'(line_far.q.size()), 32'(n));
    rdc(ADDR_STATUS, 32'h4);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fifo();
    t_rx();
    t_filter();
    t_loop();
    t_stop();
    test_done();
  end
endmodule
